// *** common/qu_pkg.sv ***
// Shared constants and types for the quad serial line block
// Function
// RQ1 - Active-low terminal-ready output per line
// RQ2 - Serial outputs active high, idle high
// RQ3 - Silo clear driven from scan enable latch
// RQ4 - Bit timing divides 5.0688 MHz by rate divisor
// RQ5 - Codes 0-7 use divisors 6336 down to 264
// RQ6 - Codes 8-14 use divisors 176 down to 33
// RQ7 - Code 15 uses divisor 16, unsupported rate
// RQ8 - 16x sampling tolerates 43.75% edge misalignment
// RQ9 - Accept characters with half stop bit
// RQ10 - Silo raises input ready, loads per shift-in
// RQ11 - Silo drops input ready after shift-in ends
// RQ12 - Silo raises output ready, latches on shift-out
// RQ13 - Silo drops output ready after shift-out ends
// RQ14 - Separate low-pair and high-pair shift-in pulses; here both pins carry the same ld_q pulse
// RQ15 - Write silo only when all inputs ready
// RQ16 - Report combined silo output ready to software
// RQ17 - Test select swaps top rate for test clock
// RQ18 - One shift-in per input-ready rise
// RQ19 - Independent per-line rate counters
package qu_pkg;
	localparam int          NLINES    = 4;
	localparam int          CLK_HZ    = 40_000_000;
	localparam int          SYS_HZ    = 5_068_800;
	localparam int          ACC_W     = 26;
	localparam int          DIV_W     = 13;
	localparam int          RATE_LSB  = 8;
	localparam int          RATE_MSB  = 11;
	localparam logic [3:0]  RATE_TEST = 4'hf;
	localparam logic [DIV_W-1:0] DIV_TABLE [16] = '{
		13'h18c0, 13'h1080, 13'h0b40, 13'h0930, 13'h0840, 13'h0420, 13'h0210, 13'h0108, // RQ5
		13'h00b0, 13'h009e, 13'h0084, 13'h0058, 13'h0042, 13'h002c, 13'h0021, 13'h0010}; // RQ6 RQ7
	// Oversampling: half bit is 8 ticks, full bit 16
	localparam logic [3:0]  HALF_BIT  = 4'h7;
	localparam logic [3:0]  FULL_BIT  = 4'hf;
	localparam logic [3:0]  TX_BITS   = 4'ha;
	localparam logic [1:0]  LOAD_CYC  = 2'h2;
	// Register offsets
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_PARAM  = 8'h04;
	localparam logic [7:0]  ADDR_TERM   = 8'h08;
	localparam logic [7:0]  ADDR_TXDATA = 8'h0c;
	localparam logic [7:0]  ADDR_STATUS = 8'h10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [7:0] data;
		logic       ferr;
	} qu_rx_t;
	typedef enum logic [1:0] {SW_IDLE = 2'h0, SW_LOAD = 2'h1, SW_WAIT = 2'h3} qu_silo_st_t;
	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2} qu_rx_st_t;
endpackage

// *** core/qu_line.sv ***
// One serial line: rate counter, 16x receiver and transmitter
`timescale 1ns/1ps
module qu_line (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Timing
	input  wire logic          sys_tick,
	input  wire logic          test_tick,
	input  wire logic          test_sel,
	input  wire logic [3:0]    rate,
	// Transmit
	input  wire logic          tx_start,
	input  wire logic [7:0]    tx_data,
	output logic               tx_busy,
	output logic               ser_out,
	// Receive
	input  wire logic          ser_in,
	input  wire logic          rx_ack,
	output logic               rx_valid,
	output qu_pkg::qu_rx_t     rx_char
);
	logic [qu_pkg::DIV_W-1:0] cnt_q, cnt_d;
	logic                     tick;
	logic                     use_test;
	logic                     reload;
	qu_pkg::qu_rx_st_t        rx_q, rx_d;
	logic [3:0]               rph_q, rph_d;
	logic [2:0]               rbit_q, rbit_d;
	logic [7:0]               rsh_q, rsh_d;
	logic                     rv_q, rv_d;
	qu_pkg::qu_rx_t           rc_q, rc_d;
	logic [9:0]               tsh_q, tsh_d;
	logic [3:0]               tph_q, tph_d;
	logic [3:0]               tleft_q, tleft_d;

	////////////////////////////////////////////////////////////////
	always_comb begin
		use_test = test_sel && (rate == qu_pkg::RATE_TEST);
		tick     = use_test ? test_tick : (sys_tick && cnt_q == '0); // RQ17
		cnt_d    = cnt_q;
		// Reload early too, else a slow rate's stale count delays a faster one
		reload   = (cnt_q == '0) || (cnt_q >= qu_pkg::DIV_TABLE[rate]);
		if (sys_tick)
			cnt_d = reload ? qu_pkg::DIV_TABLE[rate] - 1'b1 : cnt_q - 1'b1; // RQ4
	end

	////////////////////////////////////////////////////////////////
	// Start edge is sampled at mid bit; later bits at 16 tick spacing
	always_comb begin
		rx_d  = rx_q;
		rph_d = rph_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rv_d  = rv_q && !rx_ack;
		rc_d  = rc_q;
		case (rx_q)
			qu_pkg::RX_IDLE: if (!ser_in) begin
				rx_d  = qu_pkg::RX_START;
				rph_d = '0;
			end
			qu_pkg::RX_START: if (tick) begin
				rph_d = rph_q + 1'b1;
				if (rph_q == qu_pkg::HALF_BIT) begin
					rph_d  = '0;
					rbit_d = '0;
					rx_d   = ser_in ? qu_pkg::RX_IDLE : qu_pkg::RX_DATA; // RQ8
				end
			end
			qu_pkg::RX_DATA: if (tick) begin
				rph_d = rph_q + 1'b1;
				if (rph_q == qu_pkg::FULL_BIT) begin
					rsh_d  = {ser_in, rsh_q[7:1]};
					rbit_d = rbit_q + 1'b1;
					if (rbit_q == 3'h7)
						rx_d = qu_pkg::RX_STOP;
				end
			end
			qu_pkg::RX_STOP: if (tick) begin
				rph_d = rph_q + 1'b1;
				// Finish at stop mid point so a half stop bit suffices
				if (rph_q == qu_pkg::FULL_BIT) begin
					rx_d = qu_pkg::RX_IDLE; // RQ9
					rv_d = 1'b1;
					rc_d = '{data: rsh_q, ferr: !ser_in};
				end
			end
			default: rx_d = qu_pkg::RX_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		tsh_d   = tsh_q;
		tph_d   = tph_q;
		tleft_d = tleft_q;
		if (tleft_q == '0) begin
			if (tx_start) begin
				tsh_d   = {1'b1, tx_data, 1'b0};
				tph_d   = '0;
				tleft_d = qu_pkg::TX_BITS;
			end
		end else if (tick) begin
			tph_d = tph_q + 1'b1;
			if (tph_q == qu_pkg::FULL_BIT) begin
				tsh_d   = {1'b1, tsh_q[9:1]}; // RQ2
				tleft_d = tleft_q - 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q   <= '0;
			rx_q    <= qu_pkg::RX_IDLE;
			rph_q   <= '0;
			rbit_q  <= '0;
			rsh_q   <= '0;
			rv_q    <= 1'b0;
			rc_q    <= '0;
			tsh_q   <= 10'h3ff;
			tph_q   <= '0;
			tleft_q <= '0;
		end else begin
			cnt_q   <= cnt_d;
			rx_q    <= rx_d;
			rph_q   <= rph_d;
			rbit_q  <= rbit_d;
			rsh_q   <= rsh_d;
			rv_q    <= rv_d;
			rc_q    <= rc_d;
			tsh_q   <= tsh_d;
			tph_q   <= tph_d;
			tleft_q <= tleft_d;
		end
	end

	assign ser_out  = tsh_q[0];
	assign tx_busy  = (tleft_q != '0);
	assign rx_valid = rv_q;
	assign rx_char  = rc_q;

	////////////////////////////////////////////////////////////////
	rate_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
		(sys_tick && cnt_q == '0 && !rate[3]) |=> cnt_q == qu_pkg::DIV_TABLE[$past(rate)] - 1'b1)
		else $error("low rate divisor");
	rate_high_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
		(sys_tick && cnt_q == '0 && rate[3] && rate != 4'hf) |=> cnt_q == qu_pkg::DIV_TABLE[$past(rate)] - 1'b1)
		else $error("high rate divisor");
	rate_top_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
		(sys_tick && cnt_q == '0 && rate == 4'hf) |=> cnt_q == 13'h000f) else $error("top rate divisor");
	test_clk_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
		(test_sel && rate == 4'hf && test_tick && rx_q == qu_pkg::RX_START) |=> rph_q != $past(rph_q))
		else $error("test clock ignored");
	false_start_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
		(rx_q == qu_pkg::RX_START && tick && rph_q == 4'h7 && ser_in) |=> rx_q == qu_pkg::RX_IDLE)
		else $error("false start kept");
	half_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
		(rx_q == qu_pkg::RX_STOP && tick && rph_q == 4'hf) |=> (rx_q == qu_pkg::RX_IDLE && rv_q))
		else $error("stop not ended mid bit");
	idle_high_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
		!tx_busy |-> ser_out) else $error("idle line low");
	rx_char_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(rv_q));
endmodule // qu_line

// *** core/qu_top.sv ***
// Quad serial line block with silo writer and AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module qu_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial lines
	input  wire logic [3:0]  ser_in_line,
	output logic             ser_out_line0,
	output logic             ser_out_line1,
	output logic             ser_out_line2,
	output logic             ser_out_line3,
	output logic             term_ready_n_line0,
	output logic             term_ready_n_line1,
	output logic             term_ready_n_line2,
	output logic             term_ready_n_line3,
	// Test clocking
	input  wire logic        test_clk,
	input  wire logic        test_clk_select,
	// Silo
	input  wire logic        silo_in_rdy_all,
	input  wire logic        silo_out_rdy_all,
	output logic             silo_load_low_pair,
	output logic             silo_load_high_pair,
	output logic [7:0]       silo_wdata,
	output logic             silo_clear_n
);
	localparam int NL = qu_pkg::NLINES;
	logic [3:0]          rin_m, rin_s;
	logic [2:0]          tck_m;
	logic [1:0]          tsel_m, ir_m, or_m;
	logic [qu_pkg::ACC_W-1:0] acc_q, acc_d;
	logic                sys_tick_q, sys_tick_d;
	logic                scan_q, scan_d;
	logic [3:0]          term_n_q, term_n_d;
	logic [3:0]          rate_q [NL];
	logic [3:0]          rate_d [NL];
	logic [NL-1:0]       tx_start, tx_busy, ser_out, rx_valid, rx_ack;
	qu_pkg::qu_rx_t      rx_char [NL];
	logic                aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0]          awa_q, awa_d;
	logic [31:0]         wd_q, wd_d, rd_q, rd_d;
	logic [1:0]          br_q, br_d, rr_q, rr_d;
	logic                wr_go, rd_go;
	qu_pkg::qu_silo_st_t sw_q, sw_d;
	logic [1:0]          pc_q, pc_d;
	logic [7:0]          sd_q, sd_d;
	logic                ld_q, ld_d;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers; test clock edge taken from second and third stage
	always_ff @(posedge aclk) begin
		rin_m  <= ser_in_line;
		rin_s  <= rin_m;
		tck_m  <= {tck_m[1:0], test_clk};
		tsel_m <= {tsel_m[0], test_clk_select};
		ir_m   <= {ir_m[0], silo_in_rdy_all};
		or_m   <= {or_m[0], silo_out_rdy_all};
	end

	// Fractional prescaler makes the 5.0688 MHz tick from aclk
	always_comb begin
		sys_tick_d = (acc_q + qu_pkg::ACC_W'(qu_pkg::SYS_HZ)) >= qu_pkg::ACC_W'(qu_pkg::CLK_HZ);
		acc_d      = acc_q + qu_pkg::ACC_W'(qu_pkg::SYS_HZ) - (sys_tick_d ? qu_pkg::ACC_W'(qu_pkg::CLK_HZ) : '0);
	end

	////////////////////////////////////////////////////////////////
	// Each line owns its rate counter
	for (genvar i = 0; i < NL; i++) begin : g_line
		qu_line u_line (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.sys_tick  (sys_tick_q),
			.test_tick (tck_m[1] && !tck_m[2]),
			.test_sel  (tsel_m[1]),
			.rate      (rate_q[i]),
			.tx_start  (tx_start[i]),
			.tx_data   (wd_q[7:0]),
			.tx_busy   (tx_busy[i]),
			.ser_out   (ser_out[i]),
			.ser_in    (rin_s[i]),
			.rx_ack    (rx_ack[i]),
			.rx_valid  (rx_valid[i]),
			.rx_char   (rx_char[i])
		); // RQ19
		assign tx_start[i] = wr_go && awa_q == qu_pkg::ADDR_TXDATA && wd_q[9:8] == 2'(i);
		assign rx_ack[i]   = sw_q == qu_pkg::SW_IDLE && ir_m[1] && scan_q && pc_q == 2'(i) && rx_valid[i];
	end

	////////////////////////////////////////////////////////////////
	// AXI4-Lite slave; write acts once address and data are both held
	assign wr_go = aw_q && w_q && !bv_q;
	assign rd_go = s_axi_arvalid && !rv_q;

	always_comb begin
		aw_d = aw_q;
		w_d  = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		bv_d = bv_q && !s_axi_bready;
		br_d = br_q;
		rv_d = rv_q && !s_axi_rready;
		rd_d = rd_q;
		rr_d = rr_q;
		scan_d = scan_q;
		term_n_d = term_n_q;
		rate_d = rate_q;
		if (s_axi_awvalid && !aw_q) begin
			aw_d  = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q) begin
			w_d  = 1'b1;
			wd_d = s_axi_wdata;
		end
		if (wr_go) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			br_d = qu_pkg::RESP_OKAY;
			case (awa_q)
				qu_pkg::ADDR_CTRL:   scan_d = wd_q[0];
				qu_pkg::ADDR_PARAM:  rate_d[wd_q[1:0]] = wd_q[qu_pkg::RATE_MSB:qu_pkg::RATE_LSB]; // RQ4
				qu_pkg::ADDR_TERM:   term_n_d = ~wd_q[3:0]; // RQ1
				qu_pkg::ADDR_TXDATA: ;
				default:             br_d = qu_pkg::RESP_SLVERR;
			endcase
		end
		if (rd_go) begin
			rv_d = 1'b1;
			rr_d = qu_pkg::RESP_OKAY;
			case (s_axi_araddr)
				qu_pkg::ADDR_CTRL:   rd_d = {31'h0, scan_q};
				qu_pkg::ADDR_PARAM:  rd_d = {16'h0, rate_q[3], rate_q[2], rate_q[1], rate_q[0]};
				qu_pkg::ADDR_TERM:   rd_d = {28'h0, ~term_n_q};
				qu_pkg::ADDR_TXDATA: rd_d = 32'h0;
				qu_pkg::ADDR_STATUS: rd_d = {20'h0, rx_valid, tx_busy, 2'h0, ir_m[1], or_m[1]}; // RQ16
				default: begin
					rd_d = 32'h0;
					rr_d = qu_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Silo writer: both pairs load together, one load per ready rise
	always_comb begin
		sw_d = sw_q;
		pc_d = pc_q + 1'b1;
		sd_d = sd_q;
		ld_d = 1'b0;
		case (sw_q)
			qu_pkg::SW_IDLE: if (ir_m[1] && scan_q && rx_valid[pc_q]) begin // RQ15
				sw_d = qu_pkg::SW_LOAD;
				pc_d = pc_q;
				sd_d = rx_char[pc_q].data;
				ld_d = 1'b1;
			end
			// One cycle pulse; a second load waits for ready to fall and rise
			qu_pkg::SW_LOAD: begin
				pc_d = pc_q;
				sw_d = qu_pkg::SW_WAIT; // RQ18
			end
			qu_pkg::SW_WAIT: begin
				pc_d = pc_q;
				if (!ir_m[1])
					sw_d = qu_pkg::SW_IDLE; // RQ18
			end
			default: sw_d = qu_pkg::SW_IDLE;
		endcase
		if (!scan_q)
			sw_d = qu_pkg::SW_IDLE;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= '0;
			sys_tick_q <= 1'b0;
			scan_q <= 1'b0;
			term_n_q <= 4'hf;
			rate_q <= '{default: 4'h0};
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			bv_q <= 1'b0;
			br_q <= '0;
			rv_q <= 1'b0;
			rd_q <= '0;
			rr_q <= '0;
			sw_q <= qu_pkg::SW_IDLE;
			pc_q <= '0;
			sd_q <= '0;
			ld_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			sys_tick_q <= sys_tick_d;
			scan_q <= scan_d;
			term_n_q <= term_n_d;
			rate_q <= rate_d;
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
			sw_q <= sw_d;
			pc_q <= pc_d;
			sd_q <= sd_d;
			ld_q <= ld_d;
		end
	end

	////////////////////////////////////////////////////////////////
	assign s_axi_awready       = !aw_q;
	assign s_axi_wready        = !w_q;
	assign s_axi_bvalid        = bv_q;
	assign s_axi_bresp         = br_q;
	assign s_axi_arready       = !rv_q;
	assign s_axi_rvalid        = rv_q;
	assign s_axi_rdata         = rd_q;
	assign s_axi_rresp         = rr_q;
	assign {ser_out_line3, ser_out_line2, ser_out_line1, ser_out_line0} = ser_out; // RQ2
	assign {term_ready_n_line3, term_ready_n_line2, term_ready_n_line1, term_ready_n_line0} = term_n_q; // RQ1
	assign silo_clear_n        = scan_q; // RQ3
	assign silo_load_low_pair  = ld_q; // RQ14
	assign silo_load_high_pair = ld_q;
	assign silo_wdata          = sd_q;

	////////////////////////////////////////////////////////////////
	term_ready_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
		(wr_go && awa_q == 8'h08) |=> term_n_q == ~$past(wd_q[3:0])) else $error("terminal ready wrong");
	silo_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
		silo_clear_n == scan_q) else $error("silo clear wrong");
	clear_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
		$fell(scan_q) |=> sw_q == qu_pkg::SW_IDLE && !ld_q) else $error("writer runs while cleared");
	pair_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
		silo_load_low_pair == silo_load_high_pair) else $error("pair loads split");
	load_ready_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
		$rose(ld_q) |-> $past(ir_m[1]) && $past(scan_q)) else $error("load without ready");
	one_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
		ld_q |=> !ld_q) else $error("second load");
	rearm_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
		(sw_q == qu_pkg::SW_WAIT && ir_m[1] && scan_q) |=> sw_q == qu_pkg::SW_WAIT) else $error("rearmed too early");
	out_ready_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
		(rd_go && s_axi_araddr == 8'h10) |=> rd_q[0] == $past(or_m[1])) else $error("out ready status");
	load_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ld_q));
	tx_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(tx_busy[0]));
	wait_c: cover property (@(posedge aclk) disable iff (!aresetn) sw_q == qu_pkg::SW_WAIT ##1 sw_q == qu_pkg::SW_IDLE);
endmodule // qu_top

// *** sim/qu_silo_model.sv ***
// Behavioural model of the receive silo chips seen as one 8-bit store
`timescale 1ns/1ps
module qu_silo_model (
	// Clock
	input  wire logic       aclk,
	// Device side
	input  wire logic       clear_n,
	input  wire logic       ld_lo,
	input  wire logic       ld_hi,
	input  wire logic [7:0] wd,
	output logic            in_rdy,
	output logic            out_rdy,
	// Bench control: holds input ready low to stall the device
	input  wire logic       stall
);
	logic [7:0] q[$];
	logic       ld_q;
	int         st;
	int         tmr;
	int         err;

	initial begin
		in_rdy = 1'b0;
		out_rdy = 1'b0;
		ld_q = 1'b0;
		st = 0;
		tmr = 0;
		err = 0;
	end

	////////////////////////////////////////////////////////////////
	// Handshake; slip checks counted in err for the bench to compare
	always @(posedge aclk) begin
		ld_q <= ld_lo;
		if (ld_lo !== ld_hi) err++;
		if (st != 0 && ld_lo && !ld_q) err++;
		if (!clear_n) begin
			q.delete();
			st <= 0;
		end else case (st)
			0: begin
				in_rdy <= !stall && q.size() < 64;
				if (ld_lo && !ld_q) begin
					if (!in_rdy) err++;
					q.push_back(wd);
					st <= 1;
				end
			end
			1: if (!ld_lo) begin
				tmr <= 3;
				st <= 2;
			end
			2: if (tmr == 0) begin
				in_rdy <= 1'b0;
				tmr <= 6;
				st <= 3;
			end else tmr <= tmr - 1;
			default: if (tmr == 0) st <= 0; else tmr <= tmr - 1;
		endcase
		// No shift-out pin here, so output ready just tracks a non-empty store
		out_rdy <= q.size() != 0;
	end
endmodule // qu_silo_model

// *** sim/tb.sv ***
// Self-checking bench for the quad serial line block
`timescale 1ns/1ps
module tb;
	logic        aclk, aresetn, tclk, tsel, stall;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rd;
	logic [1:0]  rs;
	logic [3:0]  si;
	wire         awready, wready, bvalid, arready, rvalid;
	wire         ld_lo, ld_hi, clr_n, in_rdy, out_rdy;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  swd;
	wire  [3:0]  so, trn;
	int          n_errors, num_checks, cyc, w0, w1, t;

	qu_top DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ser_in_line(si), .ser_out_line0(so[0]), .ser_out_line1(so[1]),
		.ser_out_line2(so[2]), .ser_out_line3(so[3]),
		.term_ready_n_line0(trn[0]), .term_ready_n_line1(trn[1]),
		.term_ready_n_line2(trn[2]), .term_ready_n_line3(trn[3]),
		.test_clk(tclk), .test_clk_select(tsel),
		.silo_in_rdy_all(in_rdy), .silo_out_rdy_all(out_rdy),
		.silo_load_low_pair(ld_lo), .silo_load_high_pair(ld_hi),
		.silo_wdata(swd), .silo_clear_n(clr_n));

	qu_silo_model silo (.aclk(aclk), .clear_n(clr_n), .ld_lo(ld_lo), .ld_hi(ld_hi),
		.wd(swd), .in_rdy(in_rdy), .out_rdy(out_rdy), .stall(stall));

	////////////////////////////////////////////////////////////////
	// Clocks and hang guard; test clock is free running and unrelated in phase
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		tclk = 1'b0;
		#7;
		forever #125 tclk = ~tclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		if (n_errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Entry waits an edge so a release and a new request never share a time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		chk(rd & m, e);
	endtask

	// Width of the start bit of a 0xff character, in clock cycles
	task automatic meas(input int l, output int w);
		int n;
		n = 0;
		w = 0;
		while (so[l] && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		while (!so[l] && w < 9000) begin
			@(posedge aclk);
			w++;
		end
	endtask

	// 8N1 frame; bc cycles a bit, sc cycles of stop
	task automatic ser(input int l, input logic [7:0] b, input int bc, input int sc);
		si[l] <= 1'b0;
		repeat (bc) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			si[l] <= b[i];
			repeat (bc) @(posedge aclk);
		end
		si[l] <= 1'b1;
		repeat (sc) @(posedge aclk);
	endtask

	task wsz(input int n);
		for (t = 0; t < 3000 && silo.q.size() < n; t++) @(posedge aclk);
		chk(32'(silo.q.size()), 32'(n));
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, tsel, stall} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		si = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({23'h0, clr_n, trn, so}, 32'h0ff);
		for (int c = 0; c < 16; c++) begin
			wr(qu_pkg::ADDR_PARAM, 32'(c) << 8, qu_pkg::RESP_OKAY);
			rdc(qu_pkg::ADDR_PARAM, 32'hf, 32'(c));
		end
		wr(qu_pkg::ADDR_TERM, 32'h5, qu_pkg::RESP_OKAY);
		chk({28'h0, trn}, 32'ha);
		rdc(qu_pkg::ADDR_TERM, 32'hf, 32'h5);
		wr(8'h14, 32'h0, qu_pkg::RESP_SLVERR);
		rdc(8'h1c, 32'hffffffff, 32'h0);
		chk({30'h0, rs}, {30'h0, qu_pkg::RESP_SLVERR});
		// Line 0 at code 14, line 1 at code 15; line 2 retuned while both run
		wr(qu_pkg::ADDR_PARAM, 32'h0e00, qu_pkg::RESP_OKAY);
		wr(qu_pkg::ADDR_PARAM, 32'h0f01, qu_pkg::RESP_OKAY);
		wr(qu_pkg::ADDR_TXDATA, 32'h0ff, qu_pkg::RESP_OKAY);
		wr(qu_pkg::ADDR_TXDATA, 32'h1ff, qu_pkg::RESP_OKAY);
		fork
			meas(0, w0);
			meas(1, w1);
			wr(qu_pkg::ADDR_PARAM, 32'h0702, qu_pkg::RESP_OKAY);
		join
		// Tick phase is free running: start bit lasts 15 to 16 ticks, less the cycles the writes took
		chk(32'(w0 > 3890 && w0 < 4175), 32'h1);
		chk(32'(w1 > 1885 && w1 < 2025), 32'h1);
		tsel <= 1'b1;
		wr(qu_pkg::ADDR_PARAM, 32'h0f02, qu_pkg::RESP_OKAY);
		wr(qu_pkg::ADDR_PARAM, 32'h0f03, qu_pkg::RESP_OKAY);
		wr(qu_pkg::ADDR_CTRL, 32'h1, qu_pkg::RESP_OKAY);
		chk({31'h0, clr_n}, 32'h1);
		wr(qu_pkg::ADDR_TXDATA, 32'h2ff, qu_pkg::RESP_OKAY);
		meas(2, w0);
		chk(32'(w0 > 145 && w0 < 163), 32'h1);
		// Skewed bit lengths, half stop bits on the last two, back to back
		ser(3, 8'ha5, 166, 160);
		ser(3, 8'h3c, 154, 80);
		ser(3, 8'h0f, 160, 80);
		wsz(3);
		chk({8'h0, silo.q[0], silo.q[1], silo.q[2]}, 32'ha53c0f);
		rdc(qu_pkg::ADDR_STATUS, 32'h1, 32'h1);
		stall <= 1'b1;
		ser(3, 8'h81, 160, 160);
		rdc(qu_pkg::ADDR_STATUS, 32'h802, 32'h800);
		chk(32'(silo.q.size()), 32'h3);
		stall <= 1'b0;
		wsz(4);
		chk({24'h0, silo.q[3]}, 32'h81);
		// A low pulse shorter than half a bit must not make a character
		si[3] <= 1'b0;
		repeat (30) @(posedge aclk);
		si[3] <= 1'b1;
		repeat (300) @(posedge aclk);
		chk(32'(silo.q.size()), 32'h4);
		wr(qu_pkg::ADDR_CTRL, 32'h0, qu_pkg::RESP_OKAY);
		chk({31'h0, clr_n}, 32'h0);
		repeat (4) @(posedge aclk);
		chk(32'(silo.q.size()), 32'h0);
		rdc(qu_pkg::ADDR_STATUS, 32'h1, 32'h0);
		chk(32'(silo.err), 32'h0);
		end_of_test();
	end
endmodule // tb
